// File: obtr_regs.svh
// register offsets, field positions and reset values of the transceiver register block
`ifndef OBTR_REGS_SVH
`define OBTR_REGS_SVH

`define OBTR_ADDR_W 4
`define OBTR_OFS_CTRL 4'h0
`define OBTR_OFS_STATUS 4'h4
`define OBTR_OFS_LOG 4'h8

`define OBTR_CTRL_LOG_EN 0
`define OBTR_CTRL_ISOLATE 1
`define OBTR_CTRL_RESET 2'h1

`define OBTR_ST_DRIVE_A 16
`define OBTR_ST_DRIVE_B 17
`define OBTR_ST_LOG_AVAIL 18
`define OBTR_ST_DROP_LSB 24

`define OBTR_LOG_VALID 31
`define OBTR_LOG_DIR 8

`define OBTR_DATA_W 8
`define OBTR_LOG_DEPTH 8

`define OBTR_RESP_OKAY 2'h0
`define OBTR_RESP_SLVERR 2'h2

`endif

// File: obtr_pkg.sv
// types shared by the transceiver register block
package obtr_pkg;
  typedef enum logic {OBTR_WR_IDLE, OBTR_WR_RESP} obtr_wr_state_t;
  typedef enum logic {OBTR_RD_IDLE, OBTR_RD_DATA} obtr_rd_state_t;
  typedef enum logic {OBTR_DIR_FWD, OBTR_DIR_REV} obtr_dir_t;
endpackage : obtr_pkg

// File: obtr_edge.sv
// rising-edge detector for a capture clock sampled on the system clock
`timescale 1ns/1ps
module obtr_edge (
  input wire logic clk,
  input wire logic reset,
  input wire logic level,
  output logic rise
);
  logic prev_ff;

  // previous level; it follows the pin through reset too, so a capture clock
  // held high across reset release is not mistaken for a fresh rising edge
  always_ff @(posedge clk) begin
    prev_ff <= level;
  end

  // no edge is reported while reset is asserted
  assign rise = level & ~prev_ff & ~reset;
endmodule : obtr_edge

// File: obtr_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module obtr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty when the indexes meet
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr_ff[AW-1:0]];

  // storage is written only on an accepted push
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule : obtr_fifo

// File: obtr_top.sv
// octal bus transceiver with capture registers, capture log and axi4-lite control
// Summary of operation
// (R1) rising capture clock loads opposite bus into register
// (R2) capture ignores enables and selects entirely
// (R3) forward enable drives B, reverse enable_n drives A
// (R4) select low passes live bus, high stored word
// (R5) forward drive: live A or forward register
// (R6) reverse drive: live B or reverse register
// (R7) both enables, both selects: drive stored words
// (R8) A-to-B drive, both clocks: both registers get A
// (R9) B-to-A drive, both clocks: both registers get B
// (R10) controller staggers clocks when any select high
// (R11) non-inverting bit paths; undriven after reset
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "obtr_regs.svh"
module obtr_top #(
  parameter int DATA_W = `OBTR_DATA_W,
  parameter int LOG_DEPTH = `OBTR_LOG_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic fwd_capture_clock,
  input wire logic rev_capture_clock,
  input wire logic fwd_source_select,
  input wire logic rev_source_select,
  input wire logic fwd_drive_enable,
  input wire logic rev_drive_enable_n,
  input wire logic [DATA_W-1:0] side_a_bus_in,
  output logic [DATA_W-1:0] side_a_bus_out,
  output logic side_a_bus_oe_n,
  input wire logic [DATA_W-1:0] side_b_bus_in,
  output logic [DATA_W-1:0] side_b_bus_out,
  output logic side_b_bus_oe_n,
  output logic log_ready,
  input wire logic [`OBTR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`OBTR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int LOG_W = DATA_W + 1;

  // capture state
  logic [DATA_W-1:0] fwd_word_ff;
  logic [DATA_W-1:0] rev_word_ff;
  logic fwd_rise;
  logic rev_rise;

  // pin drive state
  logic [DATA_W-1:0] a_out_ff;
  logic [DATA_W-1:0] b_out_ff;
  logic a_oe_n_ff;
  logic b_oe_n_ff;
  logic drive_a;
  logic drive_b;
  logic [DATA_W-1:0] nxt_a_out;
  logic [DATA_W-1:0] nxt_b_out;

  // software control and status
  logic [1:0] ctrl_ff;
  logic [7:0] drop_cnt_ff;

  // capture log path
  logic rev_pend_ff;
  logic [DATA_W-1:0] rev_pend_word_ff;
  logic log_in_valid;
  logic log_in_ready;
  logic [LOG_W-1:0] log_in_data;
  logic log_out_valid;
  logic log_out_ready;
  logic [LOG_W-1:0] log_out_data;
  logic log_ready_ff;
  logic drop_now;

  // axi write side
  obtr_pkg::obtr_wr_state_t wr_state_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [`OBTR_ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff;

  // axi read side
  obtr_pkg::obtr_rd_state_t rd_state_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic ar_take;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  // the capture clocks are plain inputs; an edge is a low-to-high step between samples
  obtr_edge u_fwd_edge (
    .clk(clk),
    .reset(reset),
    .level(fwd_capture_clock),
    .rise(fwd_rise)
  );

  obtr_edge u_rev_edge (
    .clk(clk),
    .reset(reset),
    .level(rev_capture_clock),
    .rise(rev_rise)
  );

  // forward register samples the A pins as seen on the wire, whoever drives them
  always_ff @(posedge clk) begin
    if (reset) begin
      fwd_word_ff <= '0;
    end else if (fwd_rise) begin
      fwd_word_ff <= side_a_bus_in; // [R1] [R2] [R9] [R11]
    end
  end

  // reverse register samples the B pins, including a value this block drives
  always_ff @(posedge clk) begin
    if (reset) begin
      rev_word_ff <= '0;
    end else if (rev_rise) begin
      rev_word_ff <= side_b_bus_in; // [R1] [R2] [R8] [R11]
    end
  end

  // direction decode; isolate bit lets software park both sides undriven
  assign drive_b = fwd_drive_enable & ~ctrl_ff[`OBTR_CTRL_ISOLATE]; // [R3]
  assign drive_a = ~rev_drive_enable_n & ~ctrl_ff[`OBTR_CTRL_ISOLATE]; // [R3]

  // source select per direction; both drives with both selects high give the stored-word exchange
  always_comb begin
    nxt_b_out = fwd_source_select ? fwd_word_ff : side_a_bus_in; // [R4] [R5] [R7]
    nxt_a_out = rev_source_select ? rev_word_ff : side_b_bus_in; // [R4] [R6] [R7]
  end

  // pin outputs are registered, so the live path adds one clock of latency;
  // the far side capturing our driven value therefore sees it one clock late
  always_ff @(posedge clk) begin
    if (reset) begin
      b_out_ff <= '0;
      b_oe_n_ff <= 1'b1; // [R11]
    end else begin
      b_out_ff <= nxt_b_out; // [R5]
      b_oe_n_ff <= ~drive_b; // [R3] [R5]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      a_out_ff <= '0;
      a_oe_n_ff <= 1'b1; // [R11]
    end else begin
      a_out_ff <= nxt_a_out; // [R6]
      a_oe_n_ff <= ~drive_a; // [R3] [R6]
    end
  end

  assign side_a_bus_out = a_out_ff;
  assign side_a_bus_oe_n = a_oe_n_ff;
  assign side_b_bus_out = b_out_ff;
  assign side_b_bus_oe_n = b_oe_n_ff;

  // log entry: a waiting reverse entry takes the slot first, else a forward capture wins and a simultaneous reverse capture waits one clock
  always_comb begin
    log_in_valid = 1'b0;
    log_in_data = '0;
    if (ctrl_ff[`OBTR_CTRL_LOG_EN]) begin
      if (rev_pend_ff) begin
        log_in_valid = 1'b1;
        log_in_data = {1'b1, rev_pend_word_ff};
      end else if (fwd_rise) begin
        log_in_valid = 1'b1;
        log_in_data = {1'b0, side_a_bus_in};
      end else if (rev_rise) begin
        log_in_valid = 1'b1;
        log_in_data = {1'b1, side_b_bus_in};
      end
    end
  end

  // a reverse capture is deferred when the slot is busy with another entry
  always_ff @(posedge clk) begin
    if (reset) begin
      rev_pend_ff <= 1'b0;
      rev_pend_word_ff <= '0;
    end else if (rev_rise && (fwd_rise || rev_pend_ff) && ctrl_ff[`OBTR_CTRL_LOG_EN]) begin
      rev_pend_ff <= 1'b1;
      rev_pend_word_ff <= side_b_bus_in;
    end else begin
      rev_pend_ff <= 1'b0;
    end
  end

  obtr_fifo #(
    .WIDTH(LOG_W),
    .DEPTH(LOG_DEPTH)
  ) u_log_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(log_in_valid),
    .in_ready(log_in_ready),
    .in_data(log_in_data),
    .out_valid(log_out_valid),
    .out_ready(log_out_ready),
    .out_data(log_out_data)
  );

  // bus capture cannot be stalled, so a full log loses entries; count them and
  // show back-pressure to the controller so it can hold off its clocks
  assign drop_now = log_in_valid & ~log_in_ready;

  always_ff @(posedge clk) begin
    if (reset) begin
      drop_cnt_ff <= 8'h00;
      log_ready_ff <= 1'b0;
    end else begin
      log_ready_ff <= log_in_ready;
      if (drop_now && drop_cnt_ff != 8'hFF) begin
        drop_cnt_ff <= drop_cnt_ff + 8'h01;
      end
    end
  end

  assign log_ready = log_ready_ff;

  // write channel: address and data taken in either order, answer after both
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_state_ff <= obtr_pkg::OBTR_WR_IDLE;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bresp_ff <= `OBTR_RESP_OKAY;
    end else begin
      case (wr_state_ff)
        obtr_pkg::OBTR_WR_IDLE: begin
          if (s_axi_awvalid && !aw_held_ff) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
          end
          if (s_axi_wvalid && !w_held_ff) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
          end
          if (aw_held_ff && w_held_ff) begin
            wr_state_ff <= obtr_pkg::OBTR_WR_RESP;
            bresp_ff <= (aw_addr_ff == `OBTR_OFS_CTRL) ? `OBTR_RESP_OKAY : `OBTR_RESP_SLVERR;
          end
        end
        obtr_pkg::OBTR_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_ff <= obtr_pkg::OBTR_WR_IDLE;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
          end
        end
        default: begin
          wr_state_ff <= obtr_pkg::OBTR_WR_IDLE;
        end
      endcase
    end
  end

  assign s_axi_awready = (wr_state_ff == obtr_pkg::OBTR_WR_IDLE) & ~aw_held_ff;
  assign s_axi_wready = (wr_state_ff == obtr_pkg::OBTR_WR_IDLE) & ~w_held_ff;
  assign s_axi_bvalid = (wr_state_ff == obtr_pkg::OBTR_WR_RESP);
  assign s_axi_bresp = bresp_ff;

  // control register; only byte lane 0 carries bits
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= `OBTR_CTRL_RESET;
    end else if (wr_state_ff == obtr_pkg::OBTR_WR_IDLE && aw_held_ff && w_held_ff
                 && aw_addr_ff == `OBTR_OFS_CTRL && w_strb_ff[0]) begin
      ctrl_ff <= w_data_ff[1:0];
    end
  end

  // read channel: one request at a time, data one clock after the address
  assign ar_take = (rd_state_ff == obtr_pkg::OBTR_RD_IDLE) & s_axi_arvalid;
  assign log_out_ready = ar_take & (s_axi_araddr == `OBTR_OFS_LOG);

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `OBTR_RESP_OKAY;
    case (s_axi_araddr)
      `OBTR_OFS_CTRL: begin
        nxt_rdata[1:0] = ctrl_ff;
      end
      `OBTR_OFS_STATUS: begin
        nxt_rdata[7:0] = fwd_word_ff;
        nxt_rdata[15:8] = rev_word_ff;
        nxt_rdata[`OBTR_ST_DRIVE_A] = ~a_oe_n_ff;
        nxt_rdata[`OBTR_ST_DRIVE_B] = ~b_oe_n_ff;
        nxt_rdata[`OBTR_ST_LOG_AVAIL] = log_out_valid;
        nxt_rdata[31:`OBTR_ST_DROP_LSB] = drop_cnt_ff;
      end
      `OBTR_OFS_LOG: begin
        nxt_rdata[`OBTR_LOG_VALID] = log_out_valid;
        if (log_out_valid) begin
          nxt_rdata[`OBTR_LOG_DIR:0] = log_out_data;
        end
      end
      default: begin
        nxt_rresp = `OBTR_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_state_ff <= obtr_pkg::OBTR_RD_IDLE;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `OBTR_RESP_OKAY;
    end else begin
      case (rd_state_ff)
        obtr_pkg::OBTR_RD_IDLE: begin
          if (ar_take) begin
            rd_state_ff <= obtr_pkg::OBTR_RD_DATA;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
          end
        end
        obtr_pkg::OBTR_RD_DATA: begin
          if (s_axi_rready) begin
            rd_state_ff <= obtr_pkg::OBTR_RD_IDLE;
          end
        end
        default: begin
          rd_state_ff <= obtr_pkg::OBTR_RD_IDLE;
        end
      endcase
    end
  end

  assign s_axi_arready = (rd_state_ff == obtr_pkg::OBTR_RD_IDLE);
  assign s_axi_rvalid = (rd_state_ff == obtr_pkg::OBTR_RD_DATA);
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule : obtr_top

// File: obtr_top_checker.sv
// port assertions for the transceiver top
`timescale 1ns/1ps
module obtr_top_checker #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic fwd_capture_clock,
  input wire logic rev_capture_clock,
  input wire logic fwd_source_select,
  input wire logic rev_source_select,
  input wire logic fwd_drive_enable,
  input wire logic rev_drive_enable_n,
  input wire logic [DATA_W-1:0] side_a_bus_in,
  input wire logic [DATA_W-1:0] side_a_bus_out,
  input wire logic side_a_bus_oe_n,
  input wire logic [DATA_W-1:0] side_b_bus_in,
  input wire logic [DATA_W-1:0] side_b_bus_out,
  input wire logic side_b_bus_oe_n,
  input wire logic log_ready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  logic f_prev_ff;
  logic r_prev_ff;
  logic [DATA_W-1:0] f_reg_ff;
  logic [DATA_W-1:0] r_reg_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // shadow registers; previous level tracks the pin through reset, so only a
  // real low-to-high step counts as a capture
  always_ff @(posedge clk) begin
    f_prev_ff <= fwd_capture_clock;
    r_prev_ff <= rev_capture_clock;
    if (reset) begin
      f_reg_ff <= '0;
      r_reg_ff <= '0;
    end else begin
      if (fwd_capture_clock && !f_prev_ff) f_reg_ff <= side_a_bus_in;
      if (rev_capture_clock && !r_prev_ff) r_reg_ff <= side_b_bus_in;
    end
  end
  a_b_idle: assert property ($past(!fwd_drive_enable) |-> side_b_bus_oe_n)
    else $error("side b driven while off");
  a_a_idle: assert property ($past(rev_drive_enable_n) |-> side_a_bus_oe_n)
    else $error("side a driven while off");
  a_b_live: assert property (!side_b_bus_oe_n && $past(!fwd_source_select)
    |-> side_b_bus_out == $past(side_a_bus_in)) else $error("b live path wrong");
  a_a_live: assert property (!side_a_bus_oe_n && $past(!rev_source_select)
    |-> side_a_bus_out == $past(side_b_bus_in)) else $error("a live path wrong");
  a_b_stored: assert property (!side_b_bus_oe_n && $past(fwd_source_select)
    |-> side_b_bus_out == $past(f_reg_ff)) else $error("b stored word wrong");
  a_a_stored: assert property (!side_a_bus_oe_n && $past(rev_source_select)
    |-> side_a_bus_out == $past(r_reg_ff)) else $error("a stored word wrong");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held");
  c_fwd_cap: cover property (fwd_capture_clock && !f_prev_ff);
  c_both: cover property (!side_a_bus_oe_n && !side_b_bus_oe_n);
  c_full: cover property (!log_ready);
endmodule : obtr_top_checker

bind obtr_top obtr_top_checker #(.DATA_W(DATA_W)) u_chk (.*);

// File: obtr_side_model.sv
// far-side bus logic for one side of the transceiver
`timescale 1ns/1ps
module obtr_side_model #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] dut_out,
  input wire logic dut_oe_n,
  input wire logic [W-1:0] drv,
  input wire logic drv_en,
  output logic [W-1:0] wire_lvl
);
  logic [W-1:0] last_ff;
  // a released wire toggles so a stale value can never pass for data
  always_comb begin
    if (!dut_oe_n) wire_lvl = dut_out;
    else if (drv_en) wire_lvl = drv;
    else wire_lvl = ~last_ff;
  end
  always_ff @(posedge clk) begin
    last_ff <= wire_lvl;
  end
endmodule : obtr_side_model

// File: obtr_top_test.sv
// self-checking bench for the transceiver with bus logic on both sides
`timescale 1ns/1ps
module obtr_top_test;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic fcc = 1'h0, rcc = 1'h0, fss = 1'h0, rss = 1'h0, fde = 1'h0, rde_n = 1'h1;
  logic [7:0] a_drv = 8'h00, b_drv = 8'h00, a_in, a_out, b_in, b_out;
  logic a_den = 1'h1, b_den = 1'h1, a_oe_n, b_oe_n, log_ready;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, br, rr;
  int n_errors = 0, checks_done = 0;
  always #4 clk = ~clk;
  obtr_side_model u_a (.clk(clk), .dut_out(a_out), .dut_oe_n(a_oe_n), .drv(a_drv),
    .drv_en(a_den), .wire_lvl(a_in));
  obtr_side_model u_b (.clk(clk), .dut_out(b_out), .dut_oe_n(b_oe_n), .drv(b_drv),
    .drv_en(b_den), .wire_lvl(b_in));
  obtr_top dut (.clk(clk), .reset(reset), .fwd_capture_clock(fcc), .rev_capture_clock(rcc),
    .fwd_source_select(fss), .rev_source_select(rss), .fwd_drive_enable(fde),
    .rev_drive_enable_n(rde_n), .side_a_bus_in(a_in), .side_a_bus_out(a_out),
    .side_a_bus_oe_n(a_oe_n), .side_b_bus_in(b_in), .side_b_bus_out(b_out),
    .side_b_bus_oe_n(b_oe_n), .log_ready(log_ready), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  // controls packed as {fwd en, rev en_n, fwd sel, rev sel, a model on, b model on}
  task automatic ctl(input logic [5:0] c);
    @(posedge clk);
    {fde, rde_n, fss, rss, a_den, b_den} <= c;
    step(3);
  endtask : ctl
  task automatic cap(input logic f, input logic r);
    @(posedge clk);
    fcc <= f;
    rcc <= r;
    @(posedge clk);
    fcc <= 1'h0;
    rcc <= 1'h0;
    step(2);
  endtask : cap
  // both channels offered at once, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    br = bresp;
    bready <= 1'h0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rd = rdata;
    rr = rresp;
    rready <= 1'h0;
  endtask : axi_rd
  task automatic t_reset;
    chk(34'({a_oe_n, b_oe_n}), 34'h3);
    axi_rd(4'h0);
    chk({rr, rd}, 34'h1);
    axi_rd(4'hC);
    chk({rr, rd}, 34'h2_0000_0000);
    $display("test reset done");
  endtask : t_reset
  // nine captures into an eight-deep log, then drain it empty
  task automatic t_log;
    for (int i = 0; i < 9; i++) begin
      a_drv <= 8'(i);
      cap(1'h1, 1'h0);
    end
    chk(34'(log_ready), 34'h0);
    axi_rd(4'h4);
    chk({rr, rd}, 34'h0104_0008);
    for (int i = 0; i < 8; i++) begin
      axi_rd(4'h8);
      chk({rr, rd}, 34'h8000_0000 | 34'(i));
    end
    axi_rd(4'h8);
    chk({rr, rd}, 34'h0);
    axi_wr(4'h0, 32'h0);
    chk(34'(br), 34'h0);
    axi_wr(4'hC, 32'h0);
    chk(34'(br), 34'h2);
    $display("test log done");
  endtask : t_log
  task automatic t_live;
    ctl(6'h32);
    for (int i = 0; i < 8; i++) begin
      a_drv <= 8'h01 << i;
      step(3);
      chk(34'({b_oe_n, b_out}), 34'(1 << i));
    end
    b_drv <= 8'hA5;
    ctl(6'h01);
    chk(34'({a_oe_n, a_out}), 34'hA5);
    ctl(6'h13);
    chk(34'({a_oe_n, b_oe_n}), 34'h3);
    axi_wr(4'h0, 32'h2);
    ctl(6'h32);
    chk(34'(b_oe_n), 34'h1);
    axi_wr(4'h0, 32'h0);
    step(3);
    chk(34'(b_oe_n), 34'h0);
    $display("test live done");
  endtask : t_live
  task automatic t_store;
    ctl(6'h13);
    a_drv <= 8'h3C;
    b_drv <= 8'hC3;
    cap(1'h1, 1'h0);
    cap(1'h0, 1'h1);
    a_drv <= 8'h00;
    b_drv <= 8'h00;
    ctl(6'h3A);
    chk(34'(b_out), 34'h3C);
    ctl(6'h05);
    chk(34'(a_out), 34'hC3);
    ctl(6'h2C);
    chk(34'({a_out, b_out}), 34'hC33C);
    chk(34'({a_oe_n, b_oe_n}), 34'h0);
    $display("test store done");
  endtask : t_store
  // both clocks together with selects low, device driving the far pins
  task automatic t_both;
    for (int i = 0; i < 2; i++) begin
      a_drv <= 8'h96;
      b_drv <= 8'h69;
      ctl(i == 0 ? 6'h32 : 6'h01);
      cap(1'h1, 1'h1);
      axi_rd(4'h4);
      chk({rr, rd}, i == 0 ? 34'h0102_9696 : 34'h0101_6969);
    end
    $display("test both done");
  endtask : t_both
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  initial begin
    step(5);
    reset <= 1'h0;
    t_reset;
    t_log;
    t_live;
    t_store;
    t_both;
    conclude;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    conclude;
  end
endmodule : obtr_top_test
